/* rtl/dtb_pkg.sv */
/*
  Constants, field layout and state types of the trace buffer readout.
  Assumes a 12-bit APB byte address with 32-bit data.
*/
package dtb_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [11:0] DTB_WINDOW_OFS = 12'h104;
  localparam logic [11:0] DTB_COUNT_OFS = 12'h108;
  localparam logic [11:0] DTB_CTRL_OFS = 12'h10C;
  localparam logic [11:0] DTB_STATUS_OFS = 12'h110;
  localparam logic [11:0] DTB_IRQ_ST_OFS = 12'h114;
  localparam logic [11:0] DTB_IRQ_MASK_OFS = 12'h118;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTL_ARM_BIT = 0;
  localparam int CTL_PROF_BIT = 1;
  localparam int CTL_ORIG_BIT = 2;
  localparam int CTL_ALIGN_LSB = 3;
  localparam int STS_FULL_BIT = 0;
  localparam int STS_LOCK_BIT = 1;
  localparam int STS_ARM_BIT = 2;
  localparam int IRQ_FULL_BIT = 0;
  localparam int IRQ_END_BIT = 1;

  // ****************************************
  // Codes and reset values
  // ****************************************
  localparam logic [1:0] ALIGN_END = 2'h0;
  localparam logic [1:0] ALIGN_BEGIN = 2'h1;
  localparam logic [1:0] ALIGN_MID = 2'h2;
  localparam logic [1:0] ALIGN_RSVD = 2'h3;
  localparam logic [15:0] DTB_ERR_HALF = 16'hEEEE;
  localparam logic [6:0] HALF_COUNT_MAX = 7'h7F;
  localparam logic [6:0] HALF_COUNT_RST = 7'h00;
  localparam logic [7:0] RP_RST = 8'h00;
  localparam logic [1:0] IRQ_RST = 2'h0;
  localparam logic [31:0] PRDATA_RST = 32'h0000_0000;

  // Control side state, cleared by every reset
  typedef struct packed {
    logic arm;
    logic profile;
    logic origin;
    logic [1:0] align;
    logic [1:0] irq_st;
    logic [1:0] irq_mask;
    logic [31:0] prdata;
    logic pslverr;
  } dtb_ctl_t;

  // Buffer side state, reset by power-on only
  typedef struct packed {
    logic [6:0] count;
    logic full;
    logic locked;
    logic [7:0] rp;
  } dtb_keep_t;

endpackage

/* rtl/dtb_readout.sv */
/*
  Trace buffer readout: 64 lines of 64 bits, read 16 bits at a time
  through an APB window, with valid half-line counter, full flag and interrupt.
  Assumes capture logic on pclk pushes 32-bit half lines, and that a
  power-on reset also asserts presetn.
*/
// Decided for this implementation: the APB register port.
`timescale 1ns/100ps
`default_nettype none

module dtb_readout
  import dtb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trace_push,
  input wire logic [31:0] trace_half,
  input wire logic profiling_active_flag,
  output logic session_armed,
  output logic trace_origin_select,
  output logic profile_enable,
  output logic [1:0] trigger_alignment_select,
  output logic irq
);

  // ****************************************
  // Helpers
  // ****************************************

  // Word match ignoring byte offset
  function automatic logic dtb_hit(input logic [11:0] a,
                                   input logic [11:0] ofs);
    dtb_hit = (a[11:2] == ofs[11:2]);
  endfunction

  // Halfword picked from a stored half line
  function automatic logic [15:0] dtb_pick(input logic [31:0] w,
                                           input logic hi);
    dtb_pick = hi ? w[31:16] : w[15:0];
  endfunction

  // ****************************************
  // State
  // ****************************************
  dtb_ctl_t c_r;
  dtb_ctl_t c_nxt;
  dtb_keep_t k_r;
  dtb_keep_t k_nxt;
  logic [31:0] mem_r [0:127];

  logic setup;
  logic acc;
  logic win;
  logic aligned;
  logic rd_ok;
  logic push_ok;
  logic ev_full;
  logic ev_end;
  logic [15:0] half;
  logic [7:0] oldest;
  logic ctl_wr;
  logic arm_hit;
  logic mapped;

  // ****************************************
  // Decode
  // ****************************************

  // Phase and window decode
  assign setup = psel & ~penable;
  assign acc = psel & penable;
  assign win = dtb_hit(paddr, DTB_WINDOW_OFS);
  assign aligned = (paddr[1:0] == 2'h0);
  assign rd_ok = ~k_r.locked & ~c_r.arm & c_r.origin;
  assign push_ok = trace_push & c_r.arm & (c_r.align != ALIGN_RSVD);
  // Control and arming writes in the access phase
  assign ctl_wr = acc & pwrite & dtb_hit(paddr, DTB_CTRL_OFS) & pstrb[0];
  assign arm_hit = ctl_wr & pwdata[CTL_ARM_BIT];
  // Any mapped register, for the refusal check
  assign mapped = win | dtb_hit(paddr, DTB_COUNT_OFS) | dtb_hit(paddr, DTB_CTRL_OFS) |
                  dtb_hit(paddr, DTB_STATUS_OFS) | dtb_hit(paddr, DTB_IRQ_ST_OFS) |
                  dtb_hit(paddr, DTB_IRQ_MASK_OFS);
  // Halfword at the read pointer, four per line
  assign half = dtb_pick(mem_r[k_r.rp[7:1]], k_r.rp[0]);
  // Oldest line once the buffer has wrapped
  assign oldest = k_r.full ? {k_r.count[6:1], 2'b00} : RP_RST;

  // ****************************************
  // Next state
  // ****************************************

  // All register, capture and bus effects
  always_comb begin
    c_nxt = c_r;
    k_nxt = k_r;
    ev_full = 1'b0;
    ev_end = 1'b0;

    // Capture of one half line
    if (push_ok) begin
      k_nxt.count = k_r.count + 7'h01;
      if (k_r.count == HALF_COUNT_MAX) begin
        k_nxt.full = 1'b1;
        ev_full = 1'b1;
        if (c_r.align == ALIGN_BEGIN) begin
          c_nxt.arm = 1'b0;
          ev_end = 1'b1;
        end
      end
    end

    // Read data and error taken in setup
    if (setup) begin
      c_nxt.pslverr = 1'b0;
      c_nxt.prdata = PRDATA_RST;
      if (win) begin
        if (!aligned) begin
          c_nxt.prdata = {16'h0000, DTB_ERR_HALF};
        end else if (rd_ok) begin
          c_nxt.prdata = {16'h0000, half};
        end else begin
          c_nxt.prdata = {16'h0000, DTB_ERR_HALF};
        end
      end else if (dtb_hit(paddr, DTB_COUNT_OFS)) begin
        c_nxt.prdata = {25'h000_0000, k_r.count};
      end else if (dtb_hit(paddr, DTB_CTRL_OFS)) begin
        c_nxt.prdata = {27'h000_0000, c_r.align, c_r.origin,
                        c_r.profile, c_r.arm};
      end else if (dtb_hit(paddr, DTB_STATUS_OFS)) begin
        c_nxt.prdata = {29'h0000_0000, c_r.arm, k_r.locked, k_r.full};
      end else if (dtb_hit(paddr, DTB_IRQ_ST_OFS)) begin
        c_nxt.prdata = {30'h0000_0000, c_r.irq_st};
      end else if (dtb_hit(paddr, DTB_IRQ_MASK_OFS)) begin
        c_nxt.prdata = {30'h0000_0000, c_r.irq_mask};
      end else begin
        c_nxt.pslverr = 1'b1;
      end
    end

    // Completed read steps the pointer
    if (acc && !pwrite && win && aligned && rd_ok) begin
      k_nxt.rp = k_r.rp + 8'h01;
    end

    // Window write unlocks, contents untouched
    if (acc && pwrite && win && aligned && (pstrb[1:0] == 2'h3) &&
        !c_r.arm && !profiling_active_flag && !c_r.profile) begin
      k_nxt.locked = 1'b0;
      k_nxt.rp = oldest;
    end

    // Control write
    if (ctl_wr) begin
      if (!c_r.arm && !profiling_active_flag) begin
        c_nxt.profile = pwdata[CTL_PROF_BIT];
        c_nxt.origin = pwdata[CTL_ORIG_BIT];
        c_nxt.align = pwdata[CTL_ALIGN_LSB +: 2];
      end
      c_nxt.arm = pwdata[CTL_ARM_BIT];
      if (pwdata[CTL_ARM_BIT]) begin
        k_nxt.locked = 1'b1;
        k_nxt.count = HALF_COUNT_RST;
        k_nxt.full = 1'b0;
      end
    end

    // Mask write
    if (acc && pwrite && dtb_hit(paddr, DTB_IRQ_MASK_OFS) && pstrb[0]) begin
      c_nxt.irq_mask = pwdata[1:0];
    end

    // Sticky events, set wins over clear
    if (acc && pwrite && dtb_hit(paddr, DTB_IRQ_ST_OFS) && pstrb[0]) begin
      c_nxt.irq_st = c_r.irq_st & ~pwdata[1:0];
    end
    c_nxt.irq_st[IRQ_FULL_BIT] = c_nxt.irq_st[IRQ_FULL_BIT] | ev_full;
    c_nxt.irq_st[IRQ_END_BIT] = c_nxt.irq_st[IRQ_END_BIT] | ev_end;
  end

  // ****************************************
  // Registers
  // ****************************************

  // Control side, any reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c_r.arm <= 1'b0;
      c_r.profile <= 1'b0;
      c_r.origin <= 1'b0;
      c_r.align <= ALIGN_END;
      c_r.irq_st <= IRQ_RST;
      c_r.irq_mask <= IRQ_RST;
      c_r.prdata <= PRDATA_RST;
      c_r.pslverr <= 1'b0;
    end else begin
      c_r <= c_nxt;
    end
  end

  // Counter, flag, lock, pointer: power-on only
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      k_r.count <= HALF_COUNT_RST;
      k_r.full <= 1'b0;
      k_r.locked <= 1'b1;
      k_r.rp <= RP_RST;
    end else begin
      k_r <= k_nxt;
    end
  end

  // Storage has no reset at all
  always_ff @(posedge pclk) begin
    if (push_ok) begin
      mem_r[k_r.count] <= trace_half;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  // Bus answer and capture controls
  assign prdata = c_r.prdata;
  assign pready = 1'b1;
  assign pslverr = c_r.pslverr;
  assign session_armed = c_r.arm;
  assign trace_origin_select = c_r.origin;
  assign profile_enable = c_r.profile;
  assign trigger_alignment_select = c_r.align;
  assign irq = |(c_r.irq_st & c_r.irq_mask);

  // ****************************************
  // Assertions
  // ****************************************
  default clocking dtb_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn || !por_n);

  // Setup of a window read
  sequence win_rd_setup;
    psel && !penable && !pwrite && win;
  endsequence

  // Access of a completed window read
  sequence win_rd_acc;
    psel && penable && !pwrite && win;
  endsequence

  // Arming write in the access phase
  sequence arm_wr;
    arm_hit;
  endsequence

  // Half line push into the last slot
  sequence last_push;
    push_ok && (k_r.count == HALF_COUNT_MAX);
  endsequence

  valid_read_a: assert property (
    win_rd_setup and (aligned && rd_ok) |=> prdata[15:0] == $past(half)
  ) else $error("valid window read returned wrong halfword");

  misalign_err_a: assert property (
    win_rd_setup and !aligned |=> prdata == 32'h0000_EEEE && !pslverr
  ) else $error("misaligned window read not flagged");

  misalign_hold_a: assert property (
    psel && penable && win && !aligned && !(pwrite && pstrb[1:0] == 2'h3)
    |=> $stable(k_r.rp)
  ) else $error("misaligned access moved the read pointer");

  locked_err_a: assert property (
    win_rd_setup and aligned && (c_r.arm || k_r.locked)
    |=> prdata[15:0] == DTB_ERR_HALF
  ) else $error("armed or locked read returned data");

  unlock_wr_a: assert property (
    psel && penable && pwrite && win && aligned && pstrb[1:0] == 2'h3 &&
    !c_r.arm && !c_r.profile && !profiling_active_flag
    |=> !k_r.locked && k_r.rp == $past(oldest)
  ) else $error("aligned idle window write did not unlock");

  ptr_step_a: assert property (
    win_rd_acc and (aligned && rd_ok) |=> k_r.rp == $past(k_r.rp) + 8'h01
  ) else $error("valid read did not advance the pointer");

  arm_lock_a: assert property (
    arm_wr |=> k_r.locked && c_r.arm ##1 k_r.locked
  ) else $error("arming did not lock the buffer");

  count_step_a: assert property (
    push_ok && !arm_hit |=> k_r.count == $past(k_r.count) + 7'h01
  ) else $error("counter did not count a half line");

  full_set_a: assert property (
    last_push and !arm_hit |=> k_r.full && k_r.count == HALF_COUNT_RST
  ) else $error("rollover did not set the full flag");

  full_hold_a: assert property (
    k_r.full && !arm_hit |=> k_r.full
  ) else $error("full flag dropped without arming");

  wrap_keep_a: assert property (
    last_push and (c_r.align != ALIGN_BEGIN) && !ctl_wr
    |=> c_r.arm && k_r.full
  ) else $error("end or mid alignment stopped at rollover");

  begin_stop_a: assert property (
    last_push and (c_r.align == ALIGN_BEGIN) && !arm_hit
    |=> !c_r.arm && c_r.irq_st[IRQ_END_BIT]
  ) else $error("begin alignment did not end the session");

  arm_clear_a: assert property (
    arm_wr |=> k_r.count == HALF_COUNT_RST && !k_r.full
  ) else $error("arming did not clear the counter");

  count_ro_a: assert property (
    !push_ok && !arm_hit |=> $stable(k_r.count)
  ) else $error("counter changed without a push or arming");

  origin_err_a: assert property (
    win_rd_setup and aligned && !c_r.origin |=> prdata[15:0] == DTB_ERR_HALF
  ) else $error("read with trace origin clear returned data");

  lock_hold_a: assert property (
    k_r.locked && !(acc && pwrite && win) |=> k_r.locked
  ) else $error("buffer unlocked without a window write");

  ctl_gate_a: assert property (
    ctl_wr && (c_r.arm || profiling_active_flag)
    |=> $stable(c_r.align) && $stable(c_r.origin) && $stable(c_r.profile)
  ) else $error("control fields changed while armed or profiling");

  unmapped_err_a: assert property (
    psel && !penable && !mapped |=> pslverr && prdata == PRDATA_RST
  ) else $error("unmapped address not refused");

  irq_set_a: assert property (
    ev_full |=> c_r.irq_st[IRQ_FULL_BIT]
  ) else $error("rollover event not latched");

  irq_clear_a: assert property (
    acc && pwrite && dtb_hit(paddr, DTB_IRQ_ST_OFS) && pstrb[0] &&
    pwdata[IRQ_FULL_BIT] && !ev_full |=> !c_r.irq_st[IRQ_FULL_BIT]
  ) else $error("writing one did not clear the full event");

  irq_level_a: assert property (
    irq == ((c_r.irq_st & c_r.irq_mask) != 2'h0)
  ) else $error("interrupt level disagrees with unmasked events");

endmodule // dtb_readout

`default_nettype wire

/* bench/test_debug_trace_buffer_readout.sv */
/*
  Self-checking bench of the trace buffer readout: APB master tasks,
  random half-line pushes and a table of the halves of the latest push.
  Assumes dtb_pkg and dtb_readout are compiled before this file.
*/
`timescale 1ns/100ps
`default_nettype none

module test_debug_trace_buffer_readout
  import dtb_pkg::*;
();
  logic pclk, presetn, por_n, psel, penable, pwrite, pready, pslverr, irq;
  logic trace_push, profiling_active_flag, session_armed, trace_origin_select, profile_enable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, trace_half, rsp_data;
  logic [3:0] pstrb;
  logic [1:0] trigger_alignment_select;
  logic rsp_err;
  logic [31:0] hist [0:255];
  int miscompares, num_checks, nh;
  localparam logic [31:0] ERRW = {16'h0000, DTB_ERR_HALF};
  localparam logic [1:0] ROLL_AL [2] = '{ALIGN_END, ALIGN_MID};

  dtb_readout dut (.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .trace_push(trace_push),
    .trace_half(trace_half), .profiling_active_flag(profiling_active_flag),
    .session_armed(session_armed), .trace_origin_select(trace_origin_select),
    .profile_enable(profile_enable), .trigger_alignment_select(trigger_alignment_select),
    .irq(irq));

  // 100 ns clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Level outputs once settled: irq, armed, profile, origin
  task automatic chk_pins(input logic [3:0] exp);
    @(negedge pclk);
    chk({28'h000_0000, irq, session_armed, profile_enable, trace_origin_select},
        {28'h000_0000, exp});
  endtask

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= wr ? 4'hF : 4'h0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      miscompares++;
      final_report();
    end
    rsp_data = prdata;
    rsp_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rsp_data, exp);
  endtask

  // Back-to-back capture pulses of random half lines
  task automatic push(input int n);
    logic [31:0] v;
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      v = $urandom;
      trace_push <= 1'b1;
      trace_half <= v;
      hist[i % 256] = v;
    end
    @(posedge pclk);
    trace_push <= 1'b0;
  endtask

  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask

  // Expected register images
  function automatic logic [31:0] ctl(input logic arm, input logic org, input logic [1:0] al);
    return {27'h000_0000, al, org, 1'b0, arm};
  endfunction

  function automatic logic [31:0] sts(input logic arm, input logic lck, input logic full);
    return {29'h0000_0000, arm, lck, full};
  endfunction

  function automatic logic [31:0] hw(input int k);
    logic [31:0] w;
    w = hist[(k / 2) % 256];
    return {16'h0000, (k % 2 == 1) ? w[31:16] : w[15:0]};
  endfunction

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {presetn, por_n, psel, penable, pwrite, trace_push, profiling_active_flag} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    trace_half = 32'h0000_0000;
    miscompares = 0;
    num_checks = 0;
    void'($urandom(32'h36cc));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    rdc(DTB_COUNT_OFS, 32'h0000_0000);
    rdc(DTB_STATUS_OFS, sts(1'b0, 1'b1, 1'b0));
    wr_ctl(ctl(1'b0, 1'b1, ALIGN_END));
    rdc(DTB_WINDOW_OFS, ERRW);
    profiling_active_flag <= 1'b1;
    apb(1'b1, DTB_WINDOW_OFS, 32'h0000_0000);
    profiling_active_flag <= 1'b0;
    wr_ctl(ctl(1'b0, 1'b1, ALIGN_END) | 32'h0000_0002);
    chk_pins(4'h3);
    rdc(DTB_CTRL_OFS, ctl(1'b0, 1'b1, ALIGN_END) | 32'h0000_0002);
    apb(1'b1, DTB_WINDOW_OFS, 32'h0000_0000);
    rdc(DTB_STATUS_OFS, sts(1'b0, 1'b1, 1'b0));
    tdone("lock");
    nh = 6 + ($urandom % 40);
    wr_ctl(ctl(1'b1, 1'b1, ALIGN_END));
    push(nh);
    rdc(DTB_COUNT_OFS, 32'(nh));
    rdc(DTB_WINDOW_OFS, ERRW);
    rdc(DTB_STATUS_OFS, sts(1'b1, 1'b1, 1'b0));
    wr_ctl(ctl(1'b0, 1'b1, ALIGN_END));
    apb(1'b1, DTB_WINDOW_OFS, $urandom);
    rdc(DTB_STATUS_OFS, sts(1'b0, 1'b0, 1'b0));
    for (int k = 0; k < 4; k++) rdc(DTB_WINDOW_OFS, hw(k));
    rdc(DTB_WINDOW_OFS + 12'h002, ERRW);
    rdc(DTB_WINDOW_OFS, hw(4));
    apb(1'b1, DTB_COUNT_OFS, 32'h0000_007F);
    rdc(DTB_COUNT_OFS, 32'(nh));
    wr_ctl(ctl(1'b0, 1'b0, ALIGN_END));
    rdc(DTB_WINDOW_OFS, ERRW);
    tdone("readout");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(DTB_COUNT_OFS, 32'(nh));
    wr_ctl(ctl(1'b0, 1'b1, ALIGN_END));
    rdc(DTB_WINDOW_OFS, hw(5));
    apb(1'b0, 12'h200, 32'h0000_0000);
    chk({31'h0000_0000, rsp_err}, 32'h0000_0001);
    tdone("warm reset");
    // Rollover in end and mid alignment, full interrupt masked then raised
    for (int j = 0; j < 2; j++) begin
      apb(1'b1, DTB_IRQ_MASK_OFS, 32'h0000_0000);
      wr_ctl(ctl(1'b1, 1'b1, ROLL_AL[j]));
      rdc(DTB_COUNT_OFS, 32'h0000_0000);
      chk({30'h0000_0000, trigger_alignment_select}, {30'h0000_0000, ROLL_AL[j]});
      push(130);
      rdc(DTB_COUNT_OFS, 32'h0000_0002);
      rdc(DTB_STATUS_OFS, sts(1'b1, 1'b1, 1'b1));
      chk_pins(4'h5);
      rdc(DTB_IRQ_ST_OFS, 32'h0000_0001);
      apb(1'b1, DTB_IRQ_MASK_OFS, 32'h0000_0001);
      chk_pins(4'hD);
      rdc(DTB_IRQ_MASK_OFS, 32'h0000_0001);
      apb(1'b1, DTB_IRQ_ST_OFS, 32'h0000_0001);
      chk_pins(4'h5);
      wr_ctl(ctl(1'b0, 1'b1, ROLL_AL[j]));
      apb(1'b1, DTB_WINDOW_OFS, 32'h0000_0000);
      rdc(DTB_WINDOW_OFS, hw(4));
    end
    tdone("rollover");
    apb(1'b1, DTB_IRQ_MASK_OFS, 32'h0000_0002);
    wr_ctl(ctl(1'b1, 1'b1, ALIGN_BEGIN));
    push(128);
    chk_pins(4'h9);
    rdc(DTB_STATUS_OFS, sts(1'b0, 1'b1, 1'b1));
    rdc(DTB_COUNT_OFS, 32'h0000_0000);
    rdc(DTB_IRQ_ST_OFS, 32'h0000_0003);
    chk_pins(4'h9);
    tdone("begin alignment");
    // Reserved alignment captures nothing
    wr_ctl(ctl(1'b1, 1'b1, ALIGN_RSVD));
    push(3);
    rdc(DTB_COUNT_OFS, 32'h0000_0000);
    tdone("reserved alignment");
    final_report();
  end

  task automatic wr_ctl(input logic [31:0] d);
    apb(1'b1, DTB_CTRL_OFS, d);
  endtask
endmodule // test_debug_trace_buffer_readout

`default_nettype wire
